// ### include/tic_cfg.svh
// Addresses, field positions, limits and reset values of the interval timekeeper
`ifndef TIMEKEEPER_CFG_SVH
`define TIMEKEEPER_CFG_SVH

// Register addresses on the special function register port
`define ADDR_CTRL      8'hA1
`define ADDR_SUBSEC    8'hA2
`define ADDR_SEC       8'hA3
`define ADDR_MIN       8'hA4
`define ADDR_HOUR      8'hA5
`define ADDR_COMPARE   8'hA6

// Control register field positions
`define BIT_WRAP24     6
`define BIT_TB_HI      5
`define BIT_TB_LO      4
`define BIT_SINGLE     3
`define BIT_FLAG       2
`define BIT_CNT_EN     1
`define BIT_CLK_EN     0

// Reset values
`define CTRL_RESET     8'h00
`define COMPARE_RESET  8'h00
`define TIME_RESET     8'h00

// Crystal rate and sub-second rate, prescale in crystal ticks
`define XTAL_HZ        32768
`define SUBSEC_HZ      128
`define PRESCALE       (`XTAL_HZ / `SUBSEC_HZ)
`define PRE_MAX        8'((`PRESCALE) - 1)

// Counting limits
`define SUBSEC_MAX     8'h7F
`define SEC_MAX        8'h3B
`define MIN_MAX        8'h3B
`define HOUR24_MAX     8'h17
`define HOUR255_MAX    8'hFF

// Interval counter step and wake vector
`define CNT_ZERO       8'h00
`define CNT_STEP       8'h01
`define WAKE_VECTOR    16'h0053

`endif

// ### include/tic_pkg.sv
// Types shared by the interval timekeeper design
`default_nettype none
package timekeeper_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] addr16_t;
  // Interval timebase choices
  typedef enum logic [1:0] {
    TB_SUBSEC,
    TB_SEC,
    TB_MIN,
    TB_HOUR
  } timebase_t;
endpackage
`default_nettype wire

// ### verilog/wrap_counter.sv
// Time register: counts to a limit, wraps, restores last written value when stopped
`include "tic_cfg.svh"
`default_nettype none
module wrap_counter
  import timekeeper_pkg::*;
(
  // Clock, reset, clock enable
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  ce,
  // Control
  input  wire logic  run,
  input  wire logic  inc,
  input  wire byte_t maxVal,
  // Software write
  input  wire logic  wrEn,
  input  wire byte_t wrData,
  // Result
  output byte_t      count,
  output logic       wrap
);
  byte_t shadow_reg;
  byte_t count_reg;
  byte_t count_next;

  // Wrap at or above the limit so a lowered limit still recovers
  assign wrap = run & inc & (count_reg >= maxVal);
  assign count_next = wrEn ? wrData :
                      !run ? shadow_reg :
                      wrap ? `CNT_ZERO :
                      inc  ? count_reg + `CNT_STEP : count_reg;
  assign count = count_reg;

  // Shadow and live value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shadow_reg <= `TIME_RESET;
      count_reg  <= `TIME_RESET;
    end else if (ce) begin
      if (wrEn) shadow_reg <= wrData;
      count_reg <= count_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_wrap_zero: assert property (ce && !wrEn && wrap |=> count_reg == `CNT_ZERO)
    else $error("time register did not wrap to zero");
  a_restore_last: assert property (ce && !run && !wrEn |=> count_reg == $past(shadow_reg))
    else $error("stopped time register lost last written value");
  a_step_one: assert property (ce && run && inc && !wrap && !wrEn
                                |=> count_reg == $past(count_reg) + `CNT_STEP)
    else $error("time register did not step by one");
endmodule
`default_nettype wire

// ### verilog/time_interval_counter.sv
// Interval timekeeper: time registers, interval counter, match flag and wake
`include "tic_cfg.svh"
`default_nettype none

// What this block does
// - Counts from crystal ticks, also in power-down
// - Timeout spans one tick up to 255 hours
// - Interval counter steps on selected register overflow
// - Bits 5:4 pick tick, second, minute, hour
// - Match sets sticky flag bit 2, requests interrupt
// - Flag in power-down wakes, vector 0053H
// - Bit 6 selects hours 0..23 else 0..255
// - Bit 3 single shot clears enable, else reload
// - Bit 1 enables interval counter
// - Bit 0 runs clock; clear restores written time
// - Bit 7 ignored on write, reads zero
// - Sub-second counts 0..127 then increments seconds
// - Seconds count 0..59 then increment minutes
// - Minutes count 0..59 then increment hours
// - Hours in 24-hour mode wrap after 23
module time_interval_counter
  import timekeeper_pkg::*;
(
  // Clock, reset, clock enable
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  ce,
  // Crystal tick, one pulse per 32.768 kHz period
  input  wire logic  xtalTick,
  // Special function register port
  input  wire byte_t sfrAddr,
  input  wire logic  sfrWrite,
  input  wire byte_t sfrWdata,
  output byte_t      sfrRdata,
  // Interrupt controller and power control
  input  wire logic  irqEnable,
  input  wire logic  powerDown,
  output logic       irqReq,
  output logic       wakeReq,
  output addr16_t    wakeVector
);

  // Control fields
  logic      twentyFour_reg;
  timebase_t timebase_reg;
  logic      singleShot_reg;
  logic      matchFlag_reg;
  logic      countEnable_reg;
  logic      clockEnable_reg;
  byte_t     compareVal_reg;

  // Interval counter and prescaler
  byte_t     intCnt_reg;
  byte_t     prescale_reg;

  // Registered outputs
  byte_t     rdData_reg;
  logic      irqReq_reg;
  logic      wakeReq_reg;
  addr16_t   wakeVector_reg;

  // Next values
  logic      countEnable_next;
  logic      matchFlag_next;
  byte_t     intCnt_next;
  byte_t     prescale_next;
  byte_t     rdData_next;

  // Decoded writes
  wire logic wrCtrl;
  wire logic wrSubsec;
  wire logic wrSec;
  wire logic wrMin;
  wire logic wrHour;
  wire logic wrCmp;

  // Time chain
  wire logic  subTick;
  wire logic  subWrap;
  wire logic  secWrap;
  wire logic  minWrap;
  wire logic  hourWrap;
  wire byte_t subsecCnt;
  wire byte_t secCnt;
  wire byte_t minCnt;
  wire byte_t hourCnt;
  wire byte_t hourMax;

  // Interval path
  wire logic  selTick;
  wire byte_t intCntInc;
  wire logic  matchEvt;
  wire logic  shotClear;
  wire byte_t ctrlRead;

  // Address decode of register writes
  assign wrCtrl   = sfrWrite & (sfrAddr == `ADDR_CTRL);
  assign wrSubsec = sfrWrite & (sfrAddr == `ADDR_SUBSEC);
  assign wrSec    = sfrWrite & (sfrAddr == `ADDR_SEC);
  assign wrMin    = sfrWrite & (sfrAddr == `ADDR_MIN);
  assign wrHour   = sfrWrite & (sfrAddr == `ADDR_HOUR);
  assign wrCmp    = sfrWrite & (sfrAddr == `ADDR_COMPARE);

  // Prescaler: 256 crystal ticks make one 1/128 s step
  assign subTick = clockEnable_reg & xtalTick & (prescale_reg == `PRE_MAX);
  assign prescale_next = !clockEnable_reg ? `CNT_ZERO :
                         !xtalTick        ? prescale_reg :
                         subTick          ? `CNT_ZERO :
                                            prescale_reg + `CNT_STEP;

  // Hour limit from the 24-hour select
  assign hourMax = twentyFour_reg ? `HOUR24_MAX : `HOUR255_MAX;

  // Cascaded time registers
  wrap_counter uSubsec (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .run    (clockEnable_reg),
    .inc    (subTick),
    .maxVal (`SUBSEC_MAX),
    .wrEn   (wrSubsec),
    .wrData (sfrWdata),
    .count  (subsecCnt),
    .wrap   (subWrap)
  );

  wrap_counter uSec (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .run    (clockEnable_reg),
    .inc    (subWrap),
    .maxVal (`SEC_MAX),
    .wrEn   (wrSec),
    .wrData (sfrWdata),
    .count  (secCnt),
    .wrap   (secWrap)
  );

  wrap_counter uMin (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .run    (clockEnable_reg),
    .inc    (secWrap),
    .maxVal (`MIN_MAX),
    .wrEn   (wrMin),
    .wrData (sfrWdata),
    .count  (minCnt),
    .wrap   (minWrap)
  );

  wrap_counter uHour (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .run    (clockEnable_reg),
    .inc    (minWrap),
    .maxVal (hourMax),
    .wrEn   (wrHour),
    .wrData (sfrWdata),
    .count  (hourCnt),
    .wrap   (hourWrap)
  );

  // Timebase choice feeding the interval counter
  assign selTick = (timebase_reg == TB_SUBSEC) ? subTick :
                   (timebase_reg == TB_SEC)    ? subWrap :
                   (timebase_reg == TB_MIN)    ? secWrap :
                                                 minWrap;

  // Interval compare; 8-bit count times up to 255 hours
  assign intCntInc = intCnt_reg + `CNT_STEP;
  assign matchEvt  = countEnable_reg & selTick & (intCntInc == compareVal_reg);
  assign shotClear = matchEvt & singleShot_reg;

  // Enable: software write wins, single shot clears it
  assign countEnable_next = wrCtrl    ? sfrWdata[`BIT_CNT_EN] :
                            shotClear ? 1'b0 : countEnable_reg;

  // Counter held at zero while disabled, reloads at match
  assign intCnt_next = (!countEnable_reg || matchEvt) ? `CNT_ZERO :
                       selTick ? intCntInc : intCnt_reg;

  // Flag: hardware set beats a software clear in the same cycle
  assign matchFlag_next = matchEvt |
                          (matchFlag_reg & !(wrCtrl & !sfrWdata[`BIT_FLAG]));

  // Control register read image, bit 7 reads zero
  assign ctrlRead = {1'b0, twentyFour_reg, timebase_reg, singleShot_reg,
                     matchFlag_reg, countEnable_reg, clockEnable_reg};

  // Read multiplexer
  assign rdData_next = (sfrAddr == `ADDR_CTRL)   ? ctrlRead :
                       (sfrAddr == `ADDR_SUBSEC) ? subsecCnt :
                       (sfrAddr == `ADDR_SEC)    ? secCnt :
                       (sfrAddr == `ADDR_MIN)    ? minCnt :
                       (sfrAddr == `ADDR_HOUR)   ? hourCnt :
                       (sfrAddr == `ADDR_COMPARE) ? compareVal_reg : `CNT_ZERO;

  // Control fields; bit 7 of a write is dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      twentyFour_reg  <= 1'b0;
      timebase_reg    <= TB_SUBSEC;
      singleShot_reg  <= 1'b0;
      clockEnable_reg <= 1'b0;
      compareVal_reg  <= `COMPARE_RESET;
    end else if (ce) begin
      if (wrCtrl) begin
        twentyFour_reg  <= sfrWdata[`BIT_WRAP24];
        timebase_reg    <= timebase_t'(sfrWdata[`BIT_TB_HI:`BIT_TB_LO]);
        singleShot_reg  <= sfrWdata[`BIT_SINGLE];
        clockEnable_reg <= sfrWdata[`BIT_CLK_EN];
      end
      if (wrCmp) compareVal_reg <= sfrWdata;
    end
  end

  // Interval counter, enable, flag, prescaler
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      countEnable_reg <= 1'b0;
      matchFlag_reg   <= 1'b0;
      intCnt_reg      <= `CNT_ZERO;
      prescale_reg    <= `CNT_ZERO;
    end else if (ce) begin
      countEnable_reg <= countEnable_next;
      matchFlag_reg   <= matchFlag_next;
      intCnt_reg      <= intCnt_next;
      prescale_reg    <= prescale_next;
    end
  end

  // Registered read data and interrupt side outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_reg     <= `CNT_ZERO;
      irqReq_reg     <= 1'b0;
      wakeReq_reg    <= 1'b0;
      wakeVector_reg <= `WAKE_VECTOR;
    end else if (ce) begin
      rdData_reg     <= rdData_next;
      irqReq_reg     <= matchFlag_reg & irqEnable;
      wakeReq_reg    <= matchFlag_reg & irqEnable & powerDown;
      wakeVector_reg <= `WAKE_VECTOR;
    end
  end

  assign sfrRdata   = rdData_reg;
  assign irqReq     = irqReq_reg;
  assign wakeReq    = wakeReq_reg;
  assign wakeVector = wakeVector_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Checks on the interval path and time chain
  a_match_sets_flag: assert property (ce && matchEvt |=> matchFlag_reg)
    else $error("match did not set flag");
  a_flag_sticky: assert property (ce && matchFlag_reg && !wrCtrl |=> matchFlag_reg)
    else $error("flag cleared without software");
  a_single_shot: assert property (ce && shotClear && !wrCtrl |=> !countEnable_reg)
    else $error("single shot left counter enabled");
  a_auto_reload: assert property (ce && matchEvt && !singleShot_reg && !wrCtrl
                                  |=> countEnable_reg && intCnt_reg == `CNT_ZERO)
    else $error("auto reload failed");
  a_step_on_sel: assert property (ce && countEnable_reg && selTick && !matchEvt
                                  |=> intCnt_reg == $past(intCnt_reg) + `CNT_STEP)
    else $error("interval counter missed a step");
  a_disabled_zero: assert property (ce && !countEnable_reg |=> intCnt_reg == `CNT_ZERO)
    else $error("disabled counter not at zero");
  a_tick_minute: assert property (ce && timebase_reg == TB_HOUR && countEnable_reg
                                  && !minWrap |=> intCnt_reg == $past(intCnt_reg))
    else $error("hour timebase stepped without minute wrap");
  a_hour24_wrap: assert property (ce && twentyFour_reg && clockEnable_reg && minWrap
                                  && hourCnt == `HOUR24_MAX && !wrHour
                                  |=> hourCnt == `CNT_ZERO)
    else $error("24-hour mode did not wrap");
  a_bit7_zero: assert property (ce && sfrAddr == `ADDR_CTRL |=> sfrRdata[7] == 1'b0)
    else $error("control bit 7 read nonzero");
  a_wake_req: assert property (ce && matchFlag_reg && irqEnable && powerDown
                               |=> wakeReq && wakeVector == `WAKE_VECTOR)
    else $error("wake not requested");
  a_stopped_prescale: assert property (ce && !clockEnable_reg |=> !subTick)
    else $error("time advanced while stopped");
  a_ce_freeze: assert property (!ce |=> $stable(intCnt_reg) && $stable(matchFlag_reg))
    else $error("interval state moved while clock enable low");

  // Main scenarios
  c_reload: cover property (matchEvt && !singleShot_reg);
  c_single: cover property (shotClear);
  c_hour_wrap: cover property (twentyFour_reg && minWrap && hourCnt == `HOUR24_MAX);
  c_wake: cover property (wakeReq);
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the interval timekeeper
`include "tic_cfg.svh"
`default_nettype none
module testbench
  import timekeeper_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // Design inputs
  logic    clk;
  logic    rst;
  logic    ce;
  logic    xtalTick;
  byte_t   sfrAddr;
  logic    sfrWrite;
  byte_t   sfrWdata;
  logic    irqEnable;
  logic    powerDown;
  // Design outputs
  byte_t   sfrRdata;
  logic    irqReq;
  logic    wakeReq;
  addr16_t wakeVector;
  // Bookkeeping
  int      failures;
  int      n_compared;

  time_interval_counter uut (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .xtalTick   (xtalTick),
    .sfrAddr    (sfrAddr),
    .sfrWrite   (sfrWrite),
    .sfrWdata   (sfrWdata),
    .sfrRdata   (sfrRdata),
    .irqEnable  (irqEnable),
    .powerDown  (powerDown),
    .irqReq     (irqReq),
    .wakeReq    (wakeReq),
    .wakeVector (wakeVector)
  );

  // 20 MHz clock
  always #25 clk = ~clk;

  // Compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expVal);
    n_compared++;
    if (seen !== expVal) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, expVal, seen);
    end
  endtask

  // One register write, strobe for one edge
  task automatic wr(input byte_t addr, input byte_t data);
    @(posedge clk);
    sfrAddr  <= addr;
    sfrWdata <= data;
    sfrWrite <= 1'b1;
    @(posedge clk);
    sfrWrite <= 1'b0;
  endtask

  // One register read, data one cycle after the address
  task automatic rd(input byte_t addr, input byte_t expVal, input string what);
    @(posedge clk);
    sfrAddr <= addr;
    @(posedge clk); // Registered data needs a cycle
    #1;
    check(what, {8'h00, sfrRdata}, {8'h00, expVal});
  endtask

  // Crystal ticks, one per clock
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      xtalTick <= 1'b1;
    end
    @(posedge clk);
    xtalTick <= 1'b0;
  endtask

  // Preset all four time registers
  task automatic setTime(input byte_t s, input byte_t c, input byte_t m, input byte_t h);
    wr(`ADDR_SUBSEC, s);
    wr(`ADDR_SEC, c);
    wr(`ADDR_MIN, m);
    wr(`ADDR_HOUR, h);
  endtask

  // Verdict and end of run
  task automatic final_report();
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    xtalTick = 1'b0;
    sfrAddr = 8'h00;
    sfrWrite = 1'b0;
    sfrWdata = 8'h00;
    irqEnable = 1'b0;
    powerDown = 1'b0;
    failures = 0;
    n_compared = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Reset values
    rd(`ADDR_CTRL, 8'h00, "ctrl reset");
    rd(`ADDR_COMPARE, 8'h00, "compare reset");
    rd(`ADDR_HOUR, 8'h00, "hour reset");
    check("wake vector", wakeVector, 16'h0053);
    // Unmapped places, bit 7 and flag not writable as 1
    wr(8'hA7, 8'h5A);
    rd(8'hA7, 8'h00, "unmapped");
    wr(`ADDR_CTRL, 8'h84);
    rd(`ADDR_CTRL, 8'h00, "ctrl bit7");
    wr(`ADDR_COMPARE, 8'hC3);
    rd(`ADDR_COMPARE, 8'hC3, "compare rw");
    // Full cascade rollover, hours in 0..255 mode
    setTime(8'h7F, 8'h3B, 8'h3B, 8'h17);
    wr(`ADDR_CTRL, 8'h01);
    ticks(256);
    rd(`ADDR_SUBSEC, 8'h00, "subsec wrap");
    rd(`ADDR_SEC, 8'h00, "sec wrap");
    rd(`ADDR_MIN, 8'h00, "min wrap");
    rd(`ADDR_HOUR, 8'h18, "hour 255 mode");
    // Stopping restores written time and freezes it
    wr(`ADDR_CTRL, 8'h40);
    ticks(256);
    rd(`ADDR_SUBSEC, 8'h7F, "subsec restore");
    rd(`ADDR_SEC, 8'h3B, "sec restore");
    rd(`ADDR_MIN, 8'h3B, "min restore");
    rd(`ADDR_HOUR, 8'h17, "hour restore");
    // Twenty-four hour wrap
    wr(`ADDR_CTRL, 8'h41);
    ticks(256);
    rd(`ADDR_HOUR, 8'h00, "hour 24 wrap");
    // Interval counter disabled gives no match
    wr(`ADDR_COMPARE, 8'h01);
    ticks(256);
    rd(`ADDR_CTRL, 8'h41, "disabled no flag");
    // Every timebase, single shot, flag, request and wake
    @(posedge clk);
    irqEnable <= 1'b1;
    powerDown <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_CTRL, 8'h40);
      setTime((i >= 1) ? 8'h7F : 8'h00, (i >= 2) ? 8'h3B : 8'h00,
              (i == 3) ? 8'h3B : 8'h00, 8'h00);
      wr(`ADDR_CTRL, 8'h4B | 8'(i << 4));
      ticks(256);
      rd(`ADDR_CTRL, 8'h4D | 8'(i << 4), "timebase single shot");
      check("irq request", {15'h0000, irqReq}, 16'h0001);
      check("wake request", {15'h0000, wakeReq}, 16'h0001);
    end
    // Wake only in power-down, request stays
    @(posedge clk);
    powerDown <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("irq awake", {15'h0000, irqReq}, 16'h0001);
    check("wake awake", {15'h0000, wakeReq}, 16'h0000);
    // Request follows the enable, flag cleared by software
    @(posedge clk);
    irqEnable <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("irq masked", {15'h0000, irqReq}, 16'h0000);
    check("wake masked", {15'h0000, wakeReq}, 16'h0000);
    wr(`ADDR_CTRL, 8'h40);
    rd(`ADDR_CTRL, 8'h40, "flag cleared");
    // Automatic reload restarts from zero
    wr(`ADDR_COMPARE, 8'h02);
    wr(`ADDR_CTRL, 8'h43);
    ticks(512);
    rd(`ADDR_CTRL, 8'h47, "reload match");
    wr(`ADDR_CTRL, 8'h43);
    ticks(256);
    rd(`ADDR_CTRL, 8'h43, "reload half way");
    ticks(256);
    rd(`ADDR_CTRL, 8'h47, "reload second match");
    // Clock enable low drops writes and ticks
    @(posedge clk);
    ce <= 1'b0;
    wr(`ADDR_CTRL, 8'h40);
    ticks(256);
    @(posedge clk);
    ce <= 1'b1;
    rd(`ADDR_CTRL, 8'h47, "frozen ctrl");
    rd(`ADDR_SUBSEC, 8'h03, "frozen subsec");
    final_report();
  end
endmodule
`default_nettype wire
